// *** common/edr_params.svh ***
// Constants for the energy-detect and link-diagnostics register logic.
// Assumes a 40 MHz management-side clock and 5-bit register addresses.
`ifndef EDR_PARAMS_SVH
`define EDR_PARAMS_SVH

`define EDR_ADDR_PAGE_SELECT 5'h13
`define EDR_ADDR_ED_CTRL 5'h1D
`define EDR_ADDR_CABLE_LENGTH 5'h14
`define EDR_ADDR_FREQ 5'h15
`define EDR_PAGE_DIAG 2'h2
`define EDR_THRESH_RESET 4'h1
`define EDR_LEN_UNKNOWN 8'hFF
`define EDR_BURST_PULSES 3'h4
`define EDR_BIT_ENABLE 15
`define EDR_BIT_AUTO_UP 14
`define EDR_BIT_AUTO_DOWN 13
`define EDR_BIT_BURST_DIS 11
`define EDR_BIT_PWR_STATE 10
`define EDR_BIT_ERR_MET 9
`define EDR_BIT_DATA_MET 8
`define EDR_BIT_SAMPLE 15
`define EDR_BIT_SELECT_FREQ_CONTROL 8
`define EDR_CLK_HZ 40000000
`define EDR_IDLE_SEC 2
`define EDR_IDLE_CYCLES (`EDR_CLK_HZ * `EDR_IDLE_SEC)

`endif

// *** common/edr_pkg.sv ***
// Types shared by the energy-detect and diagnostics register logic.
// Assumes the constants header is included by each user.
package edr_pkg;
  // One management access as seen by the register block.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } edr_req_s;
  // Values offered by the signal processor for sampling.
  typedef struct packed {
    logic [7:0] long_offset;
    logic [7:0] freq_control;
  } edr_dsp_s;
  typedef enum logic [1:0] {
    EDR_DOWN,
    EDR_BURST,
    EDR_UP
  } edr_pwr_e;
endpackage

// *** hdl/edr_event_ctr.sv ***
// Saturating four-bit event counter with threshold compare.
// Assumes single-cycle event pulses and a shared idle clear.
`timescale 1ns/1ps
module edr_event_ctr (
  input wire logic sys_clk, // Clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic clr, // Return count to zero.
  input wire logic evt, // One event.
  input wire logic [3:0] thresh, // Programmed threshold.
  output logic met_q // Count has reached the threshold.
);
  logic [3:0] cnt_q;

  // The count saturates so a long burst cannot wrap below the threshold.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else if (ce) begin
      if (clr) begin
        cnt_q <= 4'h0;
      end else if (evt && cnt_q != 4'hF) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Registered compare, made only on an event. A hit is one cycle long, so
  // a clear-on-read flag above it really clears until the next event.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      met_q <= 1'b0;
    end else if (ce) begin
      met_q <= !clr && evt &&
               ((cnt_q != 4'hF ? cnt_q + 4'h1 : cnt_q) >= thresh);
    end
  end
endmodule

// *** hdl/edr_regs.sv ***
// Energy-detect control/status and page-2 link diagnostics registers.
// Assumes a decoded management access port, one request per cycle, and
// detector and signal-processor inputs synchronous to sys_clk.
`timescale 1ns/1ps
`include "edr_params.svh"

module edr_regs #(
  parameter int unsigned IDLE_CYCLES = `EDR_IDLE_CYCLES
) (
  input wire logic sys_clk, // 40 MHz clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; freezes all state when low.
  input wire edr_pkg::edr_req_s req, // Management access.
  input wire logic enable_strap, // Enable value caught after reset.
  input wire logic data_evt, // One-cycle energy data event.
  input wire logic err_evt, // One-cycle energy error event.
  input wire logic energy_present, // Detector sees energy on the line.
  input wire logic link_100_up, // 100 Mb/s with link up.
  input wire logic len_valid, // Length estimator has a result.
  input wire logic [7:0] len_est, // Length estimate in metres.
  input wire edr_pkg::edr_dsp_s dsp, // Signal-processor frequency values.
  output logic [15:0] rdata_q, // Read data, valid the cycle after rd.
  output logic rvalid_q, // Read data strobe.
  output logic pulse_q, // One energy-detect data pulse.
  output logic pwr_up_q // Detector powered up.
);
  logic [1:0] page_q;
  logic en_q, auto_up_q, auto_down_q, burst_dis_q;
  logic [3:0] err_th_q, data_th_q;
  logic err_met_q, data_met_q, select_freq_control_q;
  logic [7:0] freq_q;
  logic strap_done_q;
  logic [26:0] idle_q;
  logic idle_clr;
  logic err_hit, data_hit;
  logic [2:0] burst_q;
  edr_pkg::edr_pwr_e pwr_q;
  logic diag_page;
  logic wr_ed, rd_ed, wr_freq;

  // Page-two registers only decode while page select holds the value 2.
  assign diag_page = page_q == `EDR_PAGE_DIAG;
  assign wr_ed = req.wr && req.addr == `EDR_ADDR_ED_CTRL;
  assign rd_ed = req.rd && req.addr == `EDR_ADDR_ED_CTRL;
  assign wr_freq = req.wr && diag_page && req.addr == `EDR_ADDR_FREQ;

  // Page select register.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      page_q <= 2'h0;
    end else if (ce && req.wr && req.addr == `EDR_ADDR_PAGE_SELECT) begin
      page_q <= req.wdata[1:0];
    end
  end

  // The enable strap is caught on the first enabled edge after reset,
  // since a reset flop must not take a port value.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_done_q <= 1'b0;
    end else if (ce) begin
      strap_done_q <= 1'b1;
    end
  end

  // Energy-detect control fields.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_q <= 1'b0;
      auto_up_q <= 1'b1;
      auto_down_q <= 1'b1;
      burst_dis_q <= 1'b0;
      err_th_q <= `EDR_THRESH_RESET;
      data_th_q <= `EDR_THRESH_RESET;
    end else if (ce) begin
      if (!strap_done_q) begin
        en_q <= enable_strap;
      end else if (wr_ed) begin
        en_q <= req.wdata[`EDR_BIT_ENABLE];
      end
      if (wr_ed) begin
        auto_up_q <= req.wdata[`EDR_BIT_AUTO_UP];
        auto_down_q <= req.wdata[`EDR_BIT_AUTO_DOWN];
        burst_dis_q <= req.wdata[`EDR_BIT_BURST_DIS];
        err_th_q <= req.wdata[7:4];
        data_th_q <= req.wdata[3:0];
      end
    end
  end

  // Idle timer restarts on every data event; expiry clears the counters.
  assign idle_clr = idle_q == 27'(IDLE_CYCLES - 1);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idle_q <= 27'h000_0000;
    end else if (ce) begin
      if (data_evt || idle_clr) begin
        idle_q <= 27'h000_0000;
      end else begin
        idle_q <= idle_q + 27'h000_0001;
      end
    end
  end

  // One counter per event kind; idle expiry and disable both clear them.
  edr_event_ctr u_err_ctr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .clr(idle_clr || !en_q),
    .evt(err_evt),
    .thresh(err_th_q),
    .met_q(err_hit)
  );
  edr_event_ctr u_data_ctr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .clr(idle_clr || !en_q),
    .evt(data_evt),
    .thresh(data_th_q),
    .met_q(data_hit)
  );

  // Sticky met flags: a new hit in the read cycle wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      err_met_q <= 1'b0;
      data_met_q <= 1'b0;
    end else if (ce) begin
      if (err_hit) begin
        err_met_q <= 1'b1;
      end else if (rd_ed) begin
        err_met_q <= 1'b0;
      end
      if (data_hit) begin
        data_met_q <= 1'b1;
      end else if (rd_ed) begin
        data_met_q <= 1'b0;
      end
    end
  end

  // Power state machine; the error flag never steers it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pwr_q <= edr_pkg::EDR_DOWN;
      burst_q <= 3'h0;
    end else if (ce) begin
      unique case (pwr_q)
        edr_pkg::EDR_DOWN: begin
          if (en_q && auto_up_q && data_hit) begin
            pwr_q <= edr_pkg::EDR_BURST;
            burst_q <= burst_dis_q ? 3'h1 : `EDR_BURST_PULSES;
          end
        end
        edr_pkg::EDR_BURST: begin
          burst_q <= burst_q - 3'h1;
          if (burst_q == 3'h1) begin
            pwr_q <= edr_pkg::EDR_UP;
          end
        end
        edr_pkg::EDR_UP: begin
          if (!en_q || (auto_down_q && !energy_present)) begin
            pwr_q <= edr_pkg::EDR_DOWN;
          end
        end
        default: pwr_q <= edr_pkg::EDR_DOWN;
      endcase
    end
  end

  // Registered pin outputs.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
      pwr_up_q <= 1'b0;
    end else if (ce) begin
      pulse_q <= pwr_q == edr_pkg::EDR_BURST;
      pwr_up_q <= pwr_q != edr_pkg::EDR_DOWN;
    end
  end

  // Frequency sample: the strobe is not stored, only the sampled value.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      select_freq_control_q <= 1'b0;
      freq_q <= 8'h00;
    end else if (ce && wr_freq) begin
      select_freq_control_q <= req.wdata[`EDR_BIT_SELECT_FREQ_CONTROL];
      if (req.wdata[`EDR_BIT_SAMPLE]) begin
        // The select bit written with the strobe picks the source.
        freq_q <= req.wdata[`EDR_BIT_SELECT_FREQ_CONTROL] ? dsp.freq_control
                                             : dsp.long_offset;
      end
    end
  end

  // Read mux; reserved bits and the sample strobe read as zero.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= req.rd;
      rdata_q <= 16'h0000;
      if (req.rd) begin
        if (req.addr == `EDR_ADDR_PAGE_SELECT) begin
          rdata_q <= {14'h0000, page_q};
        end else if (rd_ed) begin
          rdata_q <= {en_q, auto_up_q, auto_down_q, 1'b0, burst_dis_q,
                      pwr_q != edr_pkg::EDR_DOWN, err_met_q,
                      data_met_q, err_th_q, data_th_q};
        end else if (diag_page && req.addr == `EDR_ADDR_CABLE_LENGTH) begin
          rdata_q <= {8'h00,
                      (link_100_up && len_valid) ? len_est
                                                 : `EDR_LEN_UNKNOWN};
        end else if (diag_page && req.addr == `EDR_ADDR_FREQ) begin
          // Offset is passed through as a raw two's complement code.
          rdata_q <= {1'b0, 6'h00, select_freq_control_q, freq_q};
        end
      end
    end
  end

  // Assertions and covers.
  chk_err_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && err_hit |=> err_met_q) else $error("error flag not set");
  chk_data_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && data_hit |=> data_met_q) else $error("data flag not set");
  chk_err_cor: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && rd_ed && !err_hit |=> !err_met_q)
    else $error("error flag not cleared");
  chk_burst_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && pwr_q == edr_pkg::EDR_DOWN && $past(ce) && en_q && auto_up_q &&
    data_hit && !burst_dis_q ##1 ce [*4] |-> ##1 pulse_q &&
    $past(pulse_q) && $past(pulse_q, 2) && $past(pulse_q, 3))
    else $error("burst not four pulses");
  chk_single_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && pwr_q == edr_pkg::EDR_DOWN && en_q && auto_up_q && data_hit &&
    burst_dis_q ##1 ce [*2] |-> ##1 !pulse_q && $past(pulse_q))
    else $error("burst not single pulse");
  chk_len_unknown: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && req.rd && diag_page && req.addr == `EDR_ADDR_CABLE_LENGTH &&
    !(link_100_up && len_valid) |=> rdata_q == 16'h00FF)
    else $error("unknown length not FF");
  chk_freq_rd: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && req.rd && diag_page && req.addr == `EDR_ADDR_FREQ |=>
    rdata_q[15:9] == 7'h00) else $error("reserved freq bits set");
  chk_page_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && req.rd && !diag_page && req.addr == `EDR_ADDR_CABLE_LENGTH |=>
    rdata_q == 16'h0000) else $error("page two read off page");
  chk_sample_src: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && wr_freq && req.wdata[`EDR_BIT_SAMPLE] && req.wdata[`EDR_BIT_SELECT_FREQ_CONTROL]
    |=> freq_q == $past(dsp.freq_control))
    else $error("control not sampled");
  chk_auto_down: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && pwr_q == edr_pkg::EDR_UP && auto_down_q && !energy_present |=>
    pwr_q == edr_pkg::EDR_DOWN) else $error("no auto power down");
  cov_power_up: cover property (@(posedge sys_clk) disable iff (!nrst)
    pwr_q == edr_pkg::EDR_DOWN ##1 pwr_q == edr_pkg::EDR_BURST);
  cov_idle_clear: cover property (@(posedge sys_clk) disable iff (!nrst)
    idle_clr);
  cov_sample: cover property (@(posedge sys_clk) disable iff (!nrst)
    wr_freq && req.wdata[`EDR_BIT_SAMPLE]);
endmodule

// *** tb/edr_host_model.sv ***
// Station-management host model for the energy-detect register block.
// Assumes the block takes requests on the rising edge of sys_clk.
`timescale 1ns/1ps
`include "edr_params.svh"
module edr_host_model (
  input wire logic sys_clk, // Clock.
  input wire logic [15:0] rdata_q, // Read data from the block.
  input wire logic rvalid_q, // Read data strobe.
  output edr_pkg::edr_req_s req // Request to the block.
);
  logic [1:0] page_q;

  // Idle bus at time zero; the page shadow mirrors the page register.
  initial begin
    req = '0;
    page_q = 2'h0;
  end

  // One write; the request stands across exactly one rising edge.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    req = {1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    req = '0;
    if (a == `EDR_ADDR_PAGE_SELECT) page_q = d[1:0];
  endtask

  // One read; data is taken in the single cycle that the strobe stands.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic ok);
    @(negedge sys_clk);
    req = {1'b0, 1'b1, a, 16'h0000};
    @(negedge sys_clk);
    // The answer stands only in the cycle after the taking edge.
    d = rdata_q;
    ok = rvalid_q;
    req = '0;
  endtask

  // A careful host selects the diagnostics page before touching it.
  task automatic rd_diag(input logic [4:0] a, output logic [15:0] d,
                         output logic ok);
    if (page_q != `EDR_PAGE_DIAG) wr(`EDR_ADDR_PAGE_SELECT, 16'h0002);
    rd(a, d, ok);
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the energy-detect and diagnostics registers.
// Assumes the host model issues every management request.
`timescale 1ns/1ps
`include "edr_params.svh"
module tb_top;
  localparam int unsigned IDLE = 50;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic enable_strap = 1'b1;
  logic data_evt = 1'b0;
  logic err_evt = 1'b0;
  logic energy_present = 1'b1;
  logic link_100_up = 1'b0;
  logic len_valid = 1'b0;
  logic [7:0] len_est = 8'h00;
  edr_pkg::edr_dsp_s dsp = '0;
  edr_pkg::edr_req_s req;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic pulse_q;
  logic pwr_up_q;
  int error_cnt = 0;
  int n_checks = 0;
  int pulse_cnt = 0;

  // Clock and a pulse tally; the tally is cleared by the main sequence.
  // The pin is counted mid-cycle, away from the edge that launches it.
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (pulse_q === 1'b1) pulse_cnt++;

  // A short idle count keeps the two-second timeout affordable.
  edr_regs #(.IDLE_CYCLES(IDLE)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .req(req),
    .enable_strap(enable_strap), .data_evt(data_evt), .err_evt(err_evt),
    .energy_present(energy_present), .link_100_up(link_100_up),
    .len_valid(len_valid), .len_est(len_est), .dsp(dsp),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .pulse_q(pulse_q),
    .pwr_up_q(pwr_up_q));
  edr_host_model i_host (
    .sys_clk(sys_clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .req(req));

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // Read one register and compare; the strobe must stand with the data.
  task automatic rc(input logic pg2, input logic [4:0] a,
                    input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    if (pg2) i_host.rd_diag(a, d, ok);
    else i_host.rd(a, d, ok);
    chk("read strobe", 16'h0001, {15'h0000, ok});
    chk($sformatf("register %h", a), e, d);
  endtask

  // One-cycle detector event, then a settling wait.
  task automatic pulse(input logic is_err, input int n_cyc);
    @(negedge sys_clk);
    data_evt = !is_err;
    err_evt = is_err;
    @(negedge sys_clk);
    data_evt = 1'b0;
    err_evt = 1'b0;
    repeat (n_cyc) @(negedge sys_clk);
  endtask

  // Main sequence: control fields, power bursts, flags, then page two.
  initial begin
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hE011);
    rc(0, 5'h1F, 16'h0000);
    rc(0, `EDR_ADDR_CABLE_LENGTH, 16'h0000);
    pulse(0, 12);
    chk("pulses", 16'h0004, 16'(pulse_cnt));
    chk("power pin", 16'h0001, {15'h0000, pwr_up_q});
    rc(0, `EDR_ADDR_ED_CTRL, 16'hE511);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hE411);
    energy_present = 1'b0;
    repeat (4) @(negedge sys_clk);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hE011);
    chk("power pin", 16'h0000, {15'h0000, pwr_up_q});
    i_host.wr(`EDR_ADDR_ED_CTRL, 16'hE821);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hE821);
    energy_present = 1'b1;
    pulse_cnt = 0;
    pulse(0, 12);
    chk("pulses", 16'h0001, 16'(pulse_cnt));
    rc(0, `EDR_ADDR_ED_CTRL, 16'hED21);
    energy_present = 1'b0;
    repeat (4) @(negedge sys_clk);
    // With automatic power-up off the flag still sets but no burst runs.
    i_host.wr(`EDR_ADDR_ED_CTRL, 16'hA821);
    energy_present = 1'b1;
    pulse_cnt = 0;
    pulse(0, 12);
    chk("pulses", 16'h0000, 16'(pulse_cnt));
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA921);
    pulse(1, 2);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA821);
    pulse(1, 2);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hAA21);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA821);
    // Let the idle timer empty the counters left over from earlier events.
    repeat (IDLE + 10) @(negedge sys_clk);
    // Two events split by a long idle gap must not meet a threshold of two.
    i_host.wr(`EDR_ADDR_ED_CTRL, 16'hA822);
    pulse(0, IDLE + 10);
    pulse(0, 2);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA822);
    pulse(0, 2);
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA922);
    rc(1, `EDR_ADDR_FREQ, 16'h0000);
    link_100_up = 1'b1;
    len_valid = 1'b1;
    len_est = 8'h2A;
    rc(0, `EDR_ADDR_CABLE_LENGTH, 16'h002A);
    len_valid = 1'b0;
    i_host.wr(`EDR_ADDR_CABLE_LENGTH, 16'hFF00);
    rc(0, `EDR_ADDR_CABLE_LENGTH, 16'h00FF);
    dsp = {8'h80, 8'h7F};
    i_host.wr(`EDR_ADDR_FREQ, 16'h8000);
    rc(0, `EDR_ADDR_FREQ, 16'h0080);
    i_host.wr(`EDR_ADDR_FREQ, 16'hFF00);
    rc(0, `EDR_ADDR_FREQ, 16'h017F);
    i_host.wr(`EDR_ADDR_FREQ, 16'h0000);
    rc(0, `EDR_ADDR_FREQ, 16'h007F);
    // A write while the clock enable is low must leave no trace.
    ce = 1'b0;
    i_host.wr(`EDR_ADDR_ED_CTRL, 16'h0000);
    ce = 1'b1;
    rc(0, `EDR_ADDR_ED_CTRL, 16'hA822);
    give_verdict();
  end

  // Guard against a hung sequence; a run this long counts as broken.
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
